/* File: hw/lss_unit.sv */
// load, store, spill/fill and semaphore execution unit with apb control registers
//
// What this block does
// - base register gets base plus immediate or register after access used original
// - alignment check set: misaligned access inside a 4k page faults
// - alignment check clear: misaligned completes if supported, else faults
// - any access crossing a 4k-byte boundary faults regardless of alignment check
// - misaligned semaphore always faults regardless of alignment check
// - multi-byte data ordered big or little endian by byte order bit
// - legacy-mode references are always little endian
// - general loads of 1,2,4,8 bytes, narrower values zero-extended to 64 bits
// - fp loads single, double, extended, integer converted to register format
// - fp pair fills two registers; update only by twice element size
// - general fill restores value and deferred-token bit, 8 bytes only
// - fp fill loads register format unconverted, 16 bytes only
// - stores never speculative; store update by immediate only
// - stores take load sizes; no fp pair store exists
// - general spill writes value with deferred-token bit, 8 bytes only
// - fp spill writes raw format, never faults on token, 16 bytes only
// - semaphores atomic load-compute-store, never speculative, no base update
// - swap loads zero-extended memory then stores second source
// - compare-swap stores second source only when loaded equals compare value
// - fetch-and-add loads value then stores value plus immediate
// - ordered load/store variants and biased ownership hint are signalled
// - general register values carry a 65th deferred-token bit
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lss_unit (
	input  wire logic             clk,          // 125 MHz clock
	input  wire logic             sys_rst,      // synchronous reset, high
	input  wire logic             clkEn,        // freezes all state when low
	input  wire logic             psel,         // apb select
	input  wire logic             penable,      // apb access phase
	input  wire logic             pwrite,       // apb write
	input  wire logic [11:0]      paddr,        // apb byte address
	input  wire logic [31:0]      pwdata,       // apb write data
	output logic      [31:0]      prdata,       // apb read data
	output logic                  pready,       // apb ready
	output logic                  pslverr,      // apb error, unmapped
	input  wire logic             reqValid,     // issue request valid
	output logic                  reqReady,     // unit idle, takes request
	input  wire lss_pkg::lss_op_t reqOp,        // operation
	input  wire logic [1:0]       reqSize,      // gr size log2 bytes
	input  wire lss_pkg::lss_fmt_t reqFmt,      // fp memory format
	input  wire logic             reqSpec,      // speculative issue
	input  wire logic             reqLegacy,    // legacy 32-bit mode
	input  wire logic [63:0]      reqBase,      // address register value
	input  wire logic             reqUpdEn,     // base update requested
	input  wire logic             reqUpdUseReg, // update by register
	input  wire logic [63:0]      reqUpdValue,  // update amount
	input  wire logic [63:0]      reqGrData,    // gr store data / second source
	input  wire logic             reqGrToken,   // deferred-token bit of gr source
	input  wire logic [81:0]      reqFpData,    // fp store data, register format
	input  wire logic [63:0]      reqImm,       // fetch-and-add immediate
	output logic                  rspValid,     // completion pulse
	output logic                  rspFault,     // unaligned data reference fault
	output logic                  rspIllegal,   // illegal operation form
	output logic      [63:0]      rspData,      // gr load target value
	output logic                  rspToken,     // gr target deferred-token bit
	output logic      [81:0]      rspFpA,       // first fp target
	output logic      [81:0]      rspFpB,       // second fp target (pair)
	output logic                  rspBaseWrEn,  // write base register
	output logic      [63:0]      rspBaseValue, // new base register value
	output logic                  memReq,       // memory request, held to ack
	output logic                  memWrite,     // memory write
	output logic      [63:0]      memAddr,      // memory byte address
	output logic      [4:0]       memSize,      // bytes
	output logic      [127:0]     memWdata,     // byte i at address+i
	output logic                  memWtoken,    // spilled token bit
	output logic                  memLock,      // atomic hold of location
	output logic                  memOrdered,   // ordering variant
	output logic                  memBias,      // exclusive ownership hint
	input  wire logic             memAck,       // memory done
	input  wire logic [127:0]     memRdata,     // read bytes
	input  wire logic             memRtoken     // filled token bit
);
	import lss_pkg::*;

	typedef enum {ST_IDLE, ST_MEM, ST_WR} lss_state_t;

	// ==========================================================
	// decode helpers
	function automatic logic [4:0] fpBytes(input lss_fmt_t f);
		case (f)
			FMT_SGL: fpBytes = LSS_SGL_BYTES;
			FMT_EXT: fpBytes = LSS_EXT_BYTES;
			default: fpBytes = LSS_DBL_BYTES;
		endcase
	endfunction : fpBytes

	function automatic logic [4:0] accBytes(input lss_op_t o, input logic [1:0] s,
		input lss_fmt_t f);
		case (o)
			OP_LD_FILL, OP_ST_SPILL:   accBytes = LSS_GFILL_BYTES;
			OP_LDF_FILL, OP_STF_SPILL: accBytes = LSS_FFILL_BYTES;
			OP_LDF, OP_STF:            accBytes = fpBytes(f);
			OP_LDFP:                   accBytes = fpBytes(f) << 1;
			default:                   accBytes = 5'h1 << s;
		endcase
	endfunction : accBytes

	function automatic logic isStore(input lss_op_t o);
		isStore = (o == OP_ST) || (o == OP_ST_ORD) || (o == OP_ST_SPILL) ||
			(o == OP_STF) || (o == OP_STF_SPILL);
	endfunction : isStore

	function automatic logic isSema(input lss_op_t o);
		isSema = (o == OP_XCHG) || (o == OP_CMPXCHG) || (o == OP_FETCHADD);
	endfunction : isSema

	// when big is set reverse bytes inside each element of e bytes, drop bytes beyond n
	function automatic logic [127:0] orderBytes(input logic [127:0] d, input logic [4:0] n,
		input logic [4:0] e, input logic big);
		int k;
		int src;
		orderBytes = '0;
		for (k = 0; k < 16; k++) begin
			src = big ? (k - (k % int'(e)) + int'(e) - 1 - (k % int'(e))) : k;
			if (k < int'(n))
				orderBytes[k*8 +: 8] = d[src*8 +: 8];
		end
	endfunction : orderBytes

	function automatic logic [81:0] fpToReg(input logic [79:0] d, input lss_fmt_t f);
		case (f)
			FMT_SGL:
				if (d[30:23] == 8'h00)
					fpToReg = (d[22:0] == 23'h0) ? {d[31], 81'h0} :
						{d[31], LSS_SGL_REBIAS + 17'h1, 1'b0, d[22:0], 40'h0};
				else if (d[30:23] == 8'hFF)
					fpToReg = {d[31], LSS_EXP_MAX, 1'b1, d[22:0], 40'h0};
				else
					fpToReg = {d[31], {9'h0, d[30:23]} + LSS_SGL_REBIAS, 1'b1, d[22:0], 40'h0};
			FMT_DBL:
				if (d[62:52] == 11'h000)
					fpToReg = (d[51:0] == 52'h0) ? {d[63], 81'h0} :
						{d[63], LSS_DBL_REBIAS + 17'h1, 1'b0, d[51:0], 11'h0};
				else if (d[62:52] == 11'h7FF)
					fpToReg = {d[63], LSS_EXP_MAX, 1'b1, d[51:0], 11'h0};
				else
					fpToReg = {d[63], {6'h0, d[62:52]} + LSS_DBL_REBIAS, 1'b1, d[51:0], 11'h0};
			FMT_EXT:
				if (d[78:64] == 15'h0000)
					fpToReg = {d[79], 17'h0, d[63:0]};
				else if (d[78:64] == 15'h7FFF)
					fpToReg = {d[79], LSS_EXP_MAX, d[63:0]};
				else
					fpToReg = {d[79], {2'h0, d[78:64]} + LSS_EXT_REBIAS, d[63:0]};
			default: fpToReg = {1'b0, LSS_INT_EXP, d[63:0]};
		endcase
	endfunction : fpToReg

	// register format back to memory format; out-of-range exponents are truncated
	function automatic logic [79:0] regToFp(input logic [81:0] r, input lss_fmt_t f);
		logic [16:0] eS;
		logic [16:0] eD;
		logic [16:0] eX;
		eS = r[80:64] - LSS_SGL_REBIAS;
		eD = r[80:64] - LSS_DBL_REBIAS;
		eX = r[80:64] - LSS_EXT_REBIAS;
		case (f)
			FMT_SGL: regToFp = {48'h0, r[81], r[63] ? eS[7:0] : 8'h00, r[62:40]};
			FMT_DBL: regToFp = {16'h0, r[81], r[63] ? eD[10:0] : 11'h000, r[62:11]};
			FMT_EXT: regToFp = {r[81], (r[80:64] == 17'h0) ? 15'h0000 : eX[14:0], r[63:0]};
			default: regToFp = {16'h0, r[63:0]};
		endcase
	endfunction : regToFp

	// ==========================================================
	// control registers
	logic [2:0]  ctrl_reg;
	logic [63:0] cmpVal_reg;
	logic        lastFault_reg;
	logic [15:0] faultCnt_reg;
	lss_state_t  state_reg;

	logic apbSetup;
	logic apbDone;
	logic apbMapped;
	assign apbSetup  = psel && !penable;
	assign apbDone   = psel && penable && pready;
	assign apbMapped = (paddr == LSS_CTRL_OFS) || (paddr == LSS_CCVLO_OFS) ||
		(paddr == LSS_CCVHI_OFS) || (paddr == LSS_STAT_OFS);

	// no wait state: ready rises in the access phase, read data captured at setup
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (clkEn) begin
			pready  <= apbSetup;
			pslverr <= apbSetup && !apbMapped;
			if (apbSetup) begin
				case (paddr)
					LSS_CTRL_OFS:  prdata <= {29'h0, ctrl_reg};
					LSS_CCVLO_OFS: prdata <= cmpVal_reg[31:0];
					LSS_CCVHI_OFS: prdata <= cmpVal_reg[63:32];
					LSS_STAT_OFS:  prdata <= {faultCnt_reg, 14'h0, lastFault_reg,
						state_reg != ST_IDLE};
					default:       prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_reg   <= LSS_CTRL_RST;
			cmpVal_reg <= LSS_CMPVAL_RST;
		end else if (clkEn && apbDone && pwrite) begin
			if (paddr == LSS_CTRL_OFS)
				ctrl_reg <= pwdata[2:0];
			if (paddr == LSS_CCVLO_OFS)
				cmpVal_reg[31:0] <= pwdata;
			if (paddr == LSS_CCVHI_OFS)
				cmpVal_reg[63:32] <= pwdata;
		end
	end

	// ==========================================================
	// issue-time checks
	logic        take;
	logic [4:0]  nNow;
	logic [4:0]  natNow;
	logic [12:0] lastByte;
	logic        crossNow;
	logic        misalNow;
	logic        illegalNow;
	logic        faultNow;

	assign take     = clkEn && reqValid && reqReady;
	assign nNow     = accBytes(reqOp, reqSize, reqFmt);
	assign natNow   = (nNow == LSS_EXT_BYTES) ? LSS_FFILL_BYTES : nNow;
	assign lastByte = {1'b0, reqBase[11:0]} + {8'h0, nNow} - 13'h1;
	assign crossNow = lastByte > LSS_PAGE_LAST;
	assign misalNow = (reqBase[4:0] & (natNow - 5'h1)) != 5'h0;

	always_comb begin
		illegalNow = 1'b0;
		if (isStore(reqOp) && (reqSpec || (reqUpdEn && reqUpdUseReg)))
			illegalNow = 1'b1;
		if (isSema(reqOp) && (reqSpec || reqUpdEn))
			illegalNow = 1'b1;
		if ((reqOp == OP_LD_FILL || reqOp == OP_ST_SPILL) && reqSize != LSS_SZ_8B)
			illegalNow = 1'b1;
		if (reqOp == OP_LDFP && (reqFmt == FMT_EXT || (reqUpdEn && (reqUpdUseReg ||
			reqUpdValue != {59'h0, nNow}))))
			illegalNow = 1'b1;
	end

	always_comb begin
		faultNow = crossNow;
		if (misalNow && isSema(reqOp))
			faultNow = 1'b1;
		if (misalNow && ctrl_reg[LSS_AC_BIT])
			faultNow = 1'b1;
		if (misalNow && !ctrl_reg[LSS_UNAL_BIT])
			faultNow = 1'b1;
	end

	// ==========================================================
	// store data shaping, byte ordering and read results
	lss_op_t     op_reg;
	lss_fmt_t    fmt_reg;
	logic [4:0]  n_reg;
	logic [4:0]  elem_reg;
	logic        big_reg;
	logic [63:0] src2_reg;
	logic [63:0] imm_reg;
	logic [63:0] base_reg;
	logic [63:0] upd_reg;
	logic        updEn_reg;
	logic        bigNow;
	logic [127:0] rawNow;
	logic [127:0] rdOrd;
	logic [63:0]  rdZext;
	logic [63:0]  semaNext;
	logic [127:0] semaBytes;
	logic [127:0] rdShift;

	assign bigNow = ctrl_reg[LSS_BE_BIT] && !reqLegacy;

	always_comb begin
		case (reqOp)
			OP_STF:       rawNow = {48'h0, regToFp(reqFpData, reqFmt)};
			OP_STF_SPILL: rawNow = {46'h0, reqFpData};
			default:      rawNow = {64'h0, reqGrData};
		endcase
	end

	assign rdOrd   = orderBytes(memRdata, n_reg, elem_reg, big_reg);
	assign rdZext  = rdOrd[63:0];
	assign rdShift = rdOrd >> {elem_reg, 3'h0};

	always_comb begin
		case (op_reg)
			OP_FETCHADD: semaNext = rdZext + imm_reg;
			default:     semaNext = src2_reg;
		endcase
	end
	assign semaBytes = orderBytes({64'h0, semaNext}, n_reg, n_reg, big_reg);

	// ==========================================================
	// sequencing
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg    <= ST_IDLE;
			reqReady     <= 1'b0;
			rspValid     <= 1'b0;
			rspFault     <= 1'b0;
			rspIllegal   <= 1'b0;
			rspData      <= 64'h0000_0000_0000_0000;
			rspToken     <= 1'b0;
			rspFpA       <= 82'h0;
			rspFpB       <= 82'h0;
			rspBaseWrEn  <= 1'b0;
			rspBaseValue <= 64'h0000_0000_0000_0000;
			memReq       <= 1'b0;
			memWrite     <= 1'b0;
			memAddr      <= 64'h0000_0000_0000_0000;
			memSize      <= 5'h0;
			memWdata     <= 128'h0;
			memWtoken    <= 1'b0;
			memLock      <= 1'b0;
			memOrdered   <= 1'b0;
			memBias      <= 1'b0;
			op_reg       <= OP_LD;
			fmt_reg      <= FMT_SGL;
			n_reg        <= 5'h1;
			elem_reg     <= 5'h1;
			big_reg      <= 1'b0;
			src2_reg     <= 64'h0000_0000_0000_0000;
			imm_reg      <= 64'h0000_0000_0000_0000;
			base_reg     <= 64'h0000_0000_0000_0000;
			upd_reg      <= 64'h0000_0000_0000_0000;
			updEn_reg    <= 1'b0;
		end else if (clkEn) begin
			rspValid    <= 1'b0;
			rspBaseWrEn <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					reqReady <= 1'b1;
					if (take) begin
						op_reg    <= reqOp;
						fmt_reg   <= reqFmt;
						n_reg     <= nNow;
						elem_reg  <= (reqOp == OP_LDFP) ? fpBytes(reqFmt) : nNow;
						big_reg   <= bigNow;
						src2_reg  <= reqGrData;
						imm_reg   <= reqImm;
						base_reg  <= reqBase;
						upd_reg   <= reqUpdValue;
						updEn_reg <= reqUpdEn;
						if (illegalNow || faultNow) begin
							rspValid   <= 1'b1;
							rspFault   <= faultNow && !illegalNow;
							rspIllegal <= illegalNow;
						end else begin
							reqReady   <= 1'b0;
							state_reg  <= ST_MEM;
							rspFault   <= 1'b0;
							rspIllegal <= 1'b0;
							memReq     <= 1'b1;
							memWrite   <= isStore(reqOp);
							memAddr    <= reqBase;
							memSize    <= nNow;
							memWdata   <= orderBytes(rawNow, nNow, nNow, bigNow);
							memWtoken  <= (reqOp == OP_ST_SPILL) && reqGrToken;
							memLock    <= isSema(reqOp);
							memOrdered <= (reqOp == OP_LD_ORD) || (reqOp == OP_ST_ORD);
							memBias    <= reqOp == OP_BIASED_LOAD;
						end
					end
				end
				ST_MEM: begin
					if (memAck) begin
						rspData  <= rdZext;
						rspToken <= (op_reg == OP_LD_FILL) && memRtoken;
						rspFpA   <= (op_reg == OP_LDF_FILL) ? rdOrd[81:0] :
							fpToReg(rdOrd[79:0], fmt_reg);
						rspFpB   <= fpToReg(rdShift[79:0], fmt_reg);
						if (isSema(op_reg) && !(op_reg == OP_CMPXCHG && rdZext != cmpVal_reg)) begin
							memWrite  <= 1'b1;
							memWdata  <= semaBytes;
							state_reg <= ST_WR;
						end else begin
							memReq       <= 1'b0;
							memWrite     <= 1'b0;
							memLock      <= 1'b0;
							rspValid     <= 1'b1;
							rspBaseWrEn  <= updEn_reg;
							rspBaseValue <= base_reg + upd_reg;
							reqReady     <= 1'b1;
							state_reg    <= ST_IDLE;
						end
					end
				end
				ST_WR: begin
					// lock stays up from the read through this write
					if (memAck) begin
						memReq    <= 1'b0;
						memWrite  <= 1'b0;
						memLock   <= 1'b0;
						rspValid  <= 1'b1;
						reqReady  <= 1'b1;
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lastFault_reg <= 1'b0;
			faultCnt_reg  <= 16'h0000;
		end else if (clkEn && take && !illegalNow) begin
			lastFault_reg <= faultNow;
			if (faultNow)
				faultCnt_reg <= faultCnt_reg + 16'h0001;
		end
	end

	// ==========================================================
	// checks
	crossFault_a: assert property (@(posedge clk) disable iff (sys_rst)
		take && crossNow && !illegalNow |=> rspValid && rspFault && !memReq)
		else $error("page crossing access not faulted");
	acFault_a: assert property (@(posedge clk) disable iff (sys_rst)
		take && misalNow && ctrl_reg[LSS_AC_BIT] && !illegalNow |=> rspFault)
		else $error("misaligned access with check set not faulted");
	unalOk_a: assert property (@(posedge clk) disable iff (sys_rst)
		take && misalNow && !crossNow && !isSema(reqOp) && !illegalNow &&
		ctrl_reg == 3'h4 |=> memReq && !rspValid)
		else $error("supported unaligned access did not proceed");
	semaAlign_a: assert property (@(posedge clk) disable iff (sys_rst)
		take && isSema(reqOp) && misalNow && !illegalNow |=> rspFault && !memLock)
		else $error("misaligned semaphore not faulted");
	storeForm_a: assert property (@(posedge clk) disable iff (sys_rst)
		take && isStore(reqOp) && reqSpec |=> rspIllegal && rspValid && !memReq)
		else $error("speculative store accepted");
	legacyLe_a: assert property (@(posedge clk) disable iff (sys_rst)
		take && reqLegacy |=> !big_reg)
		else $error("legacy reference not little endian");
	origAddr_a: assert property (@(posedge clk) disable iff (sys_rst)
		rspValid && rspBaseWrEn |-> memAddr == base_reg &&
		rspBaseValue == $past(base_reg) + $past(upd_reg))
		else $error("base update wrong");
	zeroExt_a: assert property (@(posedge clk) disable iff (sys_rst)
		rspValid && !rspFault && !rspIllegal && op_reg == OP_LD && n_reg == 5'h1 |->
		rspData[63:8] == 56'h0)
		else $error("byte load not zero-extended");
	cmpSkip_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && state_reg == ST_MEM && memAck && op_reg == OP_CMPXCHG &&
		rdZext != cmpVal_reg |=> !memReq && !memWrite && rspValid)
		else $error("compare-swap stored on mismatch");
	semaLock_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(memWrite) && isSema(op_reg) |-> memLock && $past(memLock) &&
		memAddr == $past(memAddr))
		else $error("semaphore lock dropped between read and write");
	spillTok_a: assert property (@(posedge clk) disable iff (sys_rst)
		take && reqOp == OP_ST_SPILL && !illegalNow && !faultNow |=>
		memWtoken == $past(reqGrToken) && memSize == LSS_GFILL_BYTES)
		else $error("spill token not written");
endmodule : lss_unit
`default_nettype wire

/* File: include/lss_pkg.sv */
// shared constants and types of the load/store/semaphore unit
package lss_pkg;
	// ==========================================================
	// register map (byte addresses on the apb slave)
	localparam logic [11:0] LSS_CTRL_OFS   = 12'h000;
	localparam logic [11:0] LSS_CCVLO_OFS  = 12'h004;
	localparam logic [11:0] LSS_CCVHI_OFS  = 12'h008;
	localparam logic [11:0] LSS_STAT_OFS   = 12'h00C;
	localparam int          LSS_AC_BIT     = 0;
	localparam int          LSS_BE_BIT     = 1;
	localparam int          LSS_UNAL_BIT   = 2;
	localparam int          LSS_BUSY_BIT   = 0;
	localparam int          LSS_LFLT_BIT   = 1;
	localparam int          LSS_FCNT_POS   = 16;
	localparam logic [2:0]  LSS_CTRL_RST   = 3'h0;
	localparam logic [63:0] LSS_CMPVAL_RST = 64'h0000_0000_0000_0000;
	// ==========================================================
	// access sizes in bytes
	localparam logic [4:0]  LSS_SGL_BYTES  = 5'h4;
	localparam logic [4:0]  LSS_DBL_BYTES  = 5'h8;
	localparam logic [4:0]  LSS_EXT_BYTES  = 5'hA;
	localparam logic [4:0]  LSS_GFILL_BYTES = 5'h8;
	localparam logic [4:0]  LSS_FFILL_BYTES = 5'h10;
	localparam logic [1:0]  LSS_SZ_8B      = 2'h3;
	localparam logic [12:0] LSS_PAGE_LAST  = 13'h0FFF;
	// ==========================================================
	// register-format exponent handling
	localparam logic [16:0] LSS_SGL_REBIAS = 17'h0_FF80;
	localparam logic [16:0] LSS_DBL_REBIAS = 17'h0_FC00;
	localparam logic [16:0] LSS_EXT_REBIAS = 17'h0_C000;
	localparam logic [16:0] LSS_EXP_MAX    = 17'h1_FFFF;
	localparam logic [16:0] LSS_INT_EXP    = 17'h1_003E;
	// ==========================================================
	typedef enum logic [3:0] {
		OP_LD, OP_LD_ORD, OP_BIASED_LOAD, OP_LD_FILL, OP_LDF, OP_LDFP, OP_LDF_FILL,
		OP_ST, OP_ST_ORD, OP_ST_SPILL, OP_STF, OP_STF_SPILL,
		OP_XCHG, OP_CMPXCHG, OP_FETCHADD
	} lss_op_t;
	typedef enum logic [1:0] {FMT_SGL, FMT_DBL, FMT_EXT, FMT_INT} lss_fmt_t;
endpackage : lss_pkg

/* File: verif/lss_mem_model.sv */
// memory-side partner model: small byte memory with alternating answer latency
`timescale 1ns/1ps
`default_nettype none
module lss_mem_model (
	input  wire logic         clk,      // clock
	input  wire logic         memReq,   // request, held to ack
	input  wire logic         memWrite, // write
	input  wire logic [63:0]  memAddr,  // byte address
	input  wire logic [4:0]   memSize,  // bytes
	input  wire logic [127:0] memWdata, // byte i at address+i
	output logic              memAck,   // done, one cycle
	output logic      [127:0] memRdata  // read bytes
);
	// ==========================================================
	// only 256 bytes are kept, so addresses wrap; byte a starts as a
	logic [7:0] mem [0:255];
	logic [1:0] waitCnt;
	logic       slow;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = i[7:0];
		{memAck, memRdata, waitCnt, slow} = '0;
	end
	// read bytes flip while not acked, so stale data never looks valid
	always @(posedge clk) begin
		memAck <= 1'b0;
		memRdata <= ~memRdata;
		if (memReq && !memAck) begin
			if (waitCnt != {slow, 1'b0}) waitCnt <= waitCnt + 2'h1;
			else begin
				memAck <= 1'b1;
				waitCnt <= 2'h0;
				slow <= !slow;
				for (int i = 0; i < memSize; i++) begin
					if (memWrite) mem[8'(memAddr[7:0] + i)] = memWdata[8*i +: 8];
					else memRdata[8*i +: 8] <= mem[8'(memAddr[7:0] + i)];
				end
			end
		end
	end
endmodule : lss_mem_model
`default_nettype wire

/* File: verif/lss_unit_tb.sv */
// self-checking bench of the load/store/semaphore unit
`timescale 1ns/1ps
`default_nettype none
module lss_unit_tb;
	import lss_pkg::*;
	// ==========================================================
	logic clk = 0, sys_rst = 1, clkEn = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic reqValid = 0, reqSpec = 0, reqLegacy = 0, reqUpdEn = 0, reqUpdUseReg = 0;
	logic reqGrToken = 0, memRtoken = 0, err, bwe, reqReady, rspValid, rspFault, rspIllegal;
	logic rspToken, rspBaseWrEn, memReq, memWrite, memWtoken, memLock, memOrdered, memBias, memAck;
	lss_op_t reqOp = OP_LD;
	lss_fmt_t reqFmt = FMT_DBL;
	logic [1:0] reqSize = '0;
	logic [63:0] reqBase = '0, reqUpdValue = '0, reqGrData = '0, reqImm = '0;
	logic [63:0] rspData, rspBaseValue, memAddr;
	logic [81:0] reqFpData = '0;
	logic [81:0] rspFpA, rspFpB;
	logic ordSeen, biasSeen, tokSeen;
	logic [4:0] memSize;
	logic [127:0] memWdata, memRdata;
	int failCount = 0, nCompared = 0;
	always #4 clk = ~clk;
	lss_unit lss_unit_inst (.clk, .sys_rst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .reqValid, .reqReady, .reqOp, .reqSize, .reqFmt, .reqSpec,
		.reqLegacy, .reqBase, .reqUpdEn, .reqUpdUseReg, .reqUpdValue, .reqGrData, .reqGrToken,
		.reqFpData, .reqImm, .rspValid, .rspFault, .rspIllegal, .rspData, .rspToken, .rspFpA,
		.rspFpB, .rspBaseWrEn, .rspBaseValue, .memReq, .memWrite, .memAddr, .memSize, .memWdata,
		.memWtoken, .memLock, .memOrdered, .memBias, .memAck, .memRdata, .memRtoken);
	lss_mem_model lss_mem_model_inst (.clk, .memReq, .memWrite, .memAddr, .memSize, .memWdata,
		.memAck, .memRdata);
	// qualifiers are kept as they stood while the request was up
	always @(posedge clk)
		if (memReq) {ordSeen, biasSeen, tokSeen} <= {memOrdered, memBias, memWtoken};
	// ==========================================================
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		nCompared++;
		if (seen !== exp) begin
			failCount++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// callers enter just after a rising edge; answers are taken at the edge that samples them
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (!pready);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
		// one idle cycle, so a following call never raises psel again in this time step
		@(posedge clk);
	endtask : apb
	task automatic go(input lss_op_t op, input logic [1:0] sz, input logic [63:0] base);
		reqOp <= op;
		reqSize <= sz;
		reqBase <= base;
		reqValid <= 1;
		do @(posedge clk); while (!reqReady);
		reqValid <= 0;
		do @(posedge clk); while (!rspValid);
		bwe = rspBaseWrEn;
	endtask : go
	task automatic conclude;
		$display("compared %0d, mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	// ==========================================================
	// the tests need well under a thousand cycles; this is a wide margin
	initial begin
		#100000;
		failCount++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		apb(0, LSS_CTRL_OFS, 32'h0);
		chk(rd, 64'(LSS_CTRL_RST));
		apb(1, 12'h010, 32'h1);
		chk(err, 1);
		apb(1, LSS_CTRL_OFS, 32'h4);
		{reqUpdEn, reqUpdUseReg, reqUpdValue} <= {2'h3, 64'h10};
		go(OP_LD, 2'h0, 64'h5);
		chk(rspData, 64'h5);
		chk(bwe, 1);
		chk(rspBaseValue, 64'h15);
		reqUpdEn <= 0;
		apb(1, LSS_CTRL_OFS, 32'h6);
		go(OP_LD, 2'h2, 64'h10);
		chk(rspData, 64'h1011_1213);
		reqLegacy <= 1;
		go(OP_LD, 2'h2, 64'h10);
		chk(rspData, 64'h1312_1110);
		reqLegacy <= 0;
		$display("test access done");
		apb(1, LSS_CTRL_OFS, 32'h5);
		go(OP_LD, 2'h1, 64'h1);
		chk(rspFault, 1);
		apb(1, LSS_CTRL_OFS, 32'h0);
		go(OP_LD, 2'h1, 64'h1);
		chk(rspFault, 1);
		apb(1, LSS_CTRL_OFS, 32'h4);
		go(OP_LD, 2'h1, 64'h1);
		chk(rspFault, 0);
		chk(rspData, 64'h0201);
		go(OP_LD, 2'h1, 64'hFFF);
		chk(rspFault, 1);
		go(OP_XCHG, 2'h2, 64'h2);
		chk(rspFault, 1);
		$display("test faults done");
		reqGrData <= 64'h0123_4567_89AB_CDEF;
		go(OP_XCHG, 2'h3, 64'h20);
		chk(rspData, 64'h2726_2524_2322_2120);
		go(OP_LD, 2'h3, 64'h20);
		chk(rspData, 64'h0123_4567_89AB_CDEF);
		reqGrData <= 64'h77;
		apb(1, LSS_CCVLO_OFS, 32'h3);
		go(OP_CMPXCHG, 2'h0, 64'h30);
		chk(rspData, 64'h30);
		go(OP_LD, 2'h0, 64'h30);
		chk(rspData, 64'h30);
		apb(1, LSS_CCVLO_OFS, 32'h30);
		go(OP_CMPXCHG, 2'h0, 64'h30);
		chk(rspData, 64'h30);
		go(OP_LD, 2'h0, 64'h30);
		chk(rspData, 64'h77);
		reqImm <= 64'h5;
		go(OP_FETCHADD, 2'h0, 64'h40);
		chk(rspData, 64'h40);
		go(OP_LD, 2'h0, 64'h40);
		chk(rspData, 64'h45);
		$display("test semaphores done");
		{reqGrToken, memRtoken} <= 2'h3;
		reqFmt <= FMT_INT;
		go(OP_ST_SPILL, 2'h3, 64'h60);
		chk(tokSeen, 1);
		go(OP_LD_FILL, 2'h3, 64'h60);
		chk(rspData, 64'h77);
		chk(rspToken, 1);
		go(OP_LD_ORD, 2'h3, 64'h20);
		chk(ordSeen, 1);
		go(OP_BIASED_LOAD, 2'h3, 64'h20);
		chk(biasSeen, 1);
		go(OP_LDF, 2'h3, 64'h20);
		chk(rspFpA[63:0], 64'h0123_4567_89AB_CDEF);
		chk(rspFpA[81:64], {1'b0, LSS_INT_EXP});
		go(OP_LDFP, 2'h3, 64'h20);
		chk(rspFpB[63:0], 64'h2F2E_2D2C_2B2A_2928);
		$display("test spill fill fp done");
		reqSpec <= 1;
		go(OP_ST, 2'h3, 64'h50);
		chk(rspIllegal, 1);
		{reqSpec, reqUpdEn} <= 2'h1;
		go(OP_XCHG, 2'h3, 64'h58);
		chk(rspIllegal, 1);
		// four faulting accesses so far, none of them illegal
		apb(0, LSS_STAT_OFS, 32'h0);
		chk(rd, 64'h4 << LSS_FCNT_POS);
		$display("test illegal forms done");
		conclude();
	end
endmodule : lss_unit_tb
`default_nettype wire
